// *** hw/acx_adder.v ***
// Eight-bit adder with carry, auxiliary carry and overflow flags.
`timescale 1ns/1ps
module acx_adder (
	input  wire [7:0] i_a,
	input  wire [7:0] i_b,
	output wire [7:0] o_sum,
	output wire       o_cy,
	output wire       o_ac,
	output wire       o_ov
);
	wire [4:0] low;
	wire [3:0] mid;
	wire [1:0] top;

	// ****************************************************************
	// Split sum exposes carries out of bits 3, 6 and 7.
	// ****************************************************************
	assign low   = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
	assign mid   = {1'b0, i_a[6:4]} + {1'b0, i_b[6:4]} + {3'b000, low[4]};
	assign top   = {1'b0, i_a[7]} + {1'b0, i_b[7]} + {1'b0, mid[3]};
	assign o_sum = {top[0], mid[2:0], low[3:0]};
	assign o_cy  = top[1];
	assign o_ac  = low[4];
	assign o_ov  = top[1] ^ mid[3];
endmodule // acx_adder

// *** hw/acx_core.v ***
// Sequencer executing the absolute call and the byte add into the accumulator.
`timescale 1ns/1ps
`include "acx_defines.vh"
module acx_core (
	input  wire        i_mclk,
	input  wire        i_srst,
	input  wire [7:0]  i_code_data,
	input  wire [7:0]  i_ram_rdata,
	output reg  [15:0] o_code_addr,
	output reg         o_code_rd,
	output reg  [7:0]  o_ram_addr,
	output reg         o_ram_rd,
	output reg         o_ram_wr,
	output reg  [7:0]  o_ram_wdata,
	output reg  [15:0] o_program_counter,
	output reg  [7:0]  o_stack_pointer,
	output reg  [7:0]  o_acc,
	output reg  [7:0]  o_psw,
	output reg         o_instr_done
);
	reg  [2:0] state;
	reg  [7:0] opcode;
	reg  [7:0] byte2;
	reg  [7:0] add_b;
	wire [7:0] sum;
	wire       cy;
	wire       ac;
	wire       ov;
	wire [15:0] pc_inc;
	wire [7:0]  sp_inc;
	wire [1:0]  bank;
	wire        is_call;
	wire        is_add_reg;
	wire        is_add_ind;

	assign pc_inc     = o_program_counter + `ACX_PC_STEP;
	assign sp_inc     = o_stack_pointer + `ACX_SP_STEP;
	assign bank       = o_psw[`ACX_PSW_RS_HI:`ACX_PSW_RS_LO];
	assign is_call    = (i_code_data[4:0] == `ACX_CALL_LOW5);
	assign is_add_reg = (i_code_data[7:3] == `ACX_ADD_REG_HI5);
	assign is_add_ind = (i_code_data[7:1] == `ACX_ADD_INDIR_HI7);

	// ****************************************************************
	// Operand selection for the adder.
	// ****************************************************************
	always @* begin
		if (state == `ACX_ST_B2) begin
			add_b = i_code_data;
		end else begin
			add_b = i_ram_rdata;
		end
	end

	acx_adder u_adder (
		.i_a   (o_acc),
		.i_b   (add_b),
		.o_sum (sum),
		.o_cy  (cy),
		.o_ac  (ac),
		.o_ov  (ov)
	);

	// ****************************************************************
	// Fetch, operand access and stack push sequencer.
	// ****************************************************************
	always @(posedge i_mclk) begin
		if (i_srst) begin
			state             <= `ACX_ST_OP;
			opcode            <= 8'h00;
			byte2             <= 8'h00;
			o_code_addr       <= `ACX_PC_RESET;
			o_code_rd         <= 1'b1;
			o_ram_addr        <= 8'h00;
			o_ram_rd          <= 1'b0;
			o_ram_wr          <= 1'b0;
			o_ram_wdata       <= 8'h00;
			o_program_counter <= `ACX_PC_RESET;
			o_stack_pointer   <= `ACX_SP_RESET;
			o_acc             <= `ACX_ACC_RESET;
			o_psw             <= `ACX_PSW_RESET;
			o_instr_done      <= 1'b0;
		end else begin
			o_instr_done <= 1'b0;
			case (state)
				`ACX_ST_OP: begin
					opcode            <= i_code_data;
					o_program_counter <= pc_inc;
					o_code_addr       <= pc_inc;
					if (is_call || i_code_data == `ACX_ADD_DIRECT ||
						i_code_data == `ACX_ADD_IMMED) begin
						state <= `ACX_ST_B2;
					end else if (is_add_reg) begin
						o_ram_addr <= {3'b000, bank, i_code_data[2:0]};
						o_ram_rd   <= 1'b1;
						o_code_rd  <= 1'b0;
						state      <= `ACX_ST_OPND;
					end else if (is_add_ind) begin
						o_ram_addr <= {3'b000, bank, 2'b00, i_code_data[0]};
						o_ram_rd   <= 1'b1;
						o_code_rd  <= 1'b0;
						state      <= `ACX_ST_PTR;
					end else begin
						o_instr_done <= 1'b1;
					end
				end
				`ACX_ST_B2: begin
					byte2             <= i_code_data;
					o_program_counter <= pc_inc;
					o_code_addr       <= pc_inc;
					if (opcode[4:0] == `ACX_CALL_LOW5) begin
						o_stack_pointer <= sp_inc;
						o_ram_addr      <= sp_inc;
						o_ram_wdata     <= pc_inc[7:0];
						o_ram_wr        <= 1'b1;
						o_code_rd       <= 1'b0;
						state           <= `ACX_ST_PUSHL;
					end else if (opcode == `ACX_ADD_DIRECT) begin
						o_ram_addr <= i_code_data;
						o_ram_rd   <= 1'b1;
						o_code_rd  <= 1'b0;
						state      <= `ACX_ST_OPND;
					end else begin
						o_acc        <= sum;
						o_psw[`ACX_PSW_CY] <= cy;
						o_psw[`ACX_PSW_AC] <= ac;
						o_psw[`ACX_PSW_OV] <= ov;
						o_instr_done <= 1'b1;
						state        <= `ACX_ST_OP;
					end
				end
				`ACX_ST_PTR: begin
					o_ram_addr <= i_ram_rdata;
					state      <= `ACX_ST_OPND;
				end
				`ACX_ST_OPND: begin
					o_acc        <= sum;
					o_psw[`ACX_PSW_CY] <= cy;
					o_psw[`ACX_PSW_AC] <= ac;
					o_psw[`ACX_PSW_OV] <= ov;
					o_ram_rd     <= 1'b0;
					o_code_rd    <= 1'b1;
					o_instr_done <= 1'b1;
					state        <= `ACX_ST_OP;
				end
				`ACX_ST_PUSHL: begin
					o_stack_pointer <= sp_inc;
					o_ram_addr      <= sp_inc;
					o_ram_wdata     <= o_program_counter[15:8];
					state           <= `ACX_ST_PUSHH;
				end
				`ACX_ST_PUSHH: begin
					// Status word is left untouched on this path.
					o_ram_wr          <= 1'b0;
					o_program_counter <= {o_program_counter[15:11], opcode[7:5], byte2};
					o_code_addr       <= {o_program_counter[15:11], opcode[7:5], byte2};
					o_code_rd         <= 1'b1;
					o_instr_done      <= 1'b1;
					state             <= `ACX_ST_OP;
				end
				default: begin
					state <= `ACX_ST_OP;
				end
			endcase
		end
	end
endmodule // acx_core

// *** hw/acx_defines.vh ***
// Constants for the absolute-call and byte-add execution block.
`ifndef ACX_DEFINES_VH
`define ACX_DEFINES_VH

// ****************************************************************
// Opcode patterns.
// ****************************************************************
`define ACX_CALL_LOW5    5'h11
`define ACX_ADD_REG_HI5  5'h05
`define ACX_ADD_DIRECT   8'h25
`define ACX_ADD_INDIR_HI7 7'h13
`define ACX_ADD_IMMED    8'h24

// ****************************************************************
// Status word layout and reset values.
// ****************************************************************
`define ACX_PSW_CY       7
`define ACX_PSW_AC       6
`define ACX_PSW_RS_HI    4
`define ACX_PSW_RS_LO    3
`define ACX_PSW_OV       2
`define ACX_PSW_RESET    8'h00
`define ACX_SP_RESET     8'h07
`define ACX_ACC_RESET    8'h00
`define ACX_PC_RESET     16'h0000
`define ACX_PC_STEP      16'h0001
`define ACX_SP_STEP      8'h01

// ****************************************************************
// Sequencer states.
// ****************************************************************
`define ACX_ST_OP        3'h0
`define ACX_ST_B2        3'h1
`define ACX_ST_PTR       3'h2
`define ACX_ST_OPND      3'h3
`define ACX_ST_PUSHL     3'h4
`define ACX_ST_PUSHH     3'h5

`endif

// *** verif/acx_core_props.sv ***
// Assertions on the call and add execution block.
`timescale 1ns/1ps
module acx_core_props (
	input wire        i_mclk,
	input wire        i_srst,
	input wire [15:0] o_code_addr,
	input wire [7:0]  o_ram_addr,
	input wire        o_ram_wr,
	input wire [7:0]  o_ram_wdata,
	input wire [15:0] o_program_counter,
	input wire [7:0]  o_stack_pointer,
	input wire [7:0]  o_acc,
	input wire [7:0]  o_psw,
	input wire        o_instr_done
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	a_push_at_sp: assert property (o_ram_wr |-> o_ram_addr == o_stack_pointer)
		else $error("stack write away from stack pointer");
	a_push_pair: assert property ($rose(o_ram_wr) |=> o_ram_wr && o_ram_addr == $past(o_ram_addr) + 8'h01)
		else $error("second push not at next address");
	a_sp_step: assert property ($rose(o_ram_wr) |=> o_stack_pointer == $past(o_stack_pointer) + 8'h01)
		else $error("stack pointer not stepped");
	a_ret_bytes: assert property ($rose(o_ram_wr) |-> o_ram_wdata == o_program_counter[7:0] ##1 o_ram_wdata == o_program_counter[15:8])
		else $error("return address bytes wrong");
	a_call_retire: assert property ($rose(o_ram_wr) |-> ##2 !o_ram_wr && o_instr_done)
		else $error("call did not retire after two pushes");
	a_target_page: assert property ($fell(o_ram_wr) |-> o_program_counter[15:11] == $past(o_program_counter[15:11]) && o_code_addr == o_program_counter)
		else $error("call left its page");
	a_call_flags: assert property (o_ram_wr |=> $stable(o_psw))
		else $error("flags changed during call");
	a_acc_on_retire: assert property (!o_instr_done |-> $stable(o_acc) && $stable(o_psw))
		else $error("accumulator or flags changed without retire");
endmodule // acx_core_props
bind acx_core acx_core_props chk_u (.i_mclk(i_mclk), .i_srst(i_srst), .o_code_addr(o_code_addr),
	.o_ram_addr(o_ram_addr), .o_ram_wr(o_ram_wr), .o_ram_wdata(o_ram_wdata),
	.o_program_counter(o_program_counter), .o_stack_pointer(o_stack_pointer), .o_acc(o_acc),
	.o_psw(o_psw), .o_instr_done(o_instr_done));

// *** verif/acx_mem.sv ***
// Program memory and internal data RAM model.
`timescale 1ns/1ps
module acx_mem (
	input  wire        i_mclk,
	input  wire [15:0] i_code_addr,
	input  wire [7:0]  i_ram_addr,
	input  wire        i_ram_wr,
	input  wire [7:0]  i_ram_wdata,
	output wire [7:0]  o_code_data,
	output wire [7:0]  o_ram_rdata
);
	reg [7:0] rom [0:65535];
	reg [7:0] ram [0:255];
	integer   k;
	initial begin
		for (k = 0; k < 65536; k = k + 1) rom[k] = 8'ha5;
	end
	assign o_code_data = rom[i_code_addr];
	assign o_ram_rdata = ram[i_ram_addr];
	always @(posedge i_mclk) begin
		if (i_ram_wr) ram[i_ram_addr] <= i_ram_wdata;
	end
endmodule // acx_mem

// *** verif/tb_acx_core.sv ***
// Self-checking testbench for the call and add execution block.
`timescale 1ns/1ps
module tb_acx_core;
	reg         i_mclk = 1'b0;
	reg         i_srst = 1'b1;
	wire [7:0]  code_data, ram_rdata, ram_addr, ram_wdata, sp, acc, psw;
	wire [15:0] code_addr, pc;
	wire        ram_wr, done;
	wire        code_rd, ram_rd;
	reg  [7:0]  ea = 8'h00;
	reg  [7:0]  ep = 8'h00;
	integer     n_errors = 0;
	integer     compares = 0;
	integer     cycles = 0;
	integer     i;
	acx_core dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_code_data(code_data),
		.i_ram_rdata(ram_rdata), .o_code_addr(code_addr), .o_code_rd(code_rd),
		.o_ram_addr(ram_addr),
		.o_ram_rd(ram_rd), .o_ram_wr(ram_wr), .o_ram_wdata(ram_wdata), .o_program_counter(pc),
		.o_stack_pointer(sp), .o_acc(acc), .o_psw(psw), .o_instr_done(done));
	acx_mem mem_u (.i_mclk(i_mclk), .i_code_addr(code_addr), .i_ram_addr(ram_addr),
		.i_ram_wr(ram_wr), .i_ram_wdata(ram_wdata), .o_code_data(code_data),
		.o_ram_rdata(ram_rdata));
	initial begin
		forever #50 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			n_errors = n_errors + 1;
			final_report;
		end
	end
	task check(input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR %0t saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task step;
		begin
			@(posedge i_mclk);
			#1;
			while (done !== 1'b1) begin
				@(posedge i_mclk);
				#1;
			end
		end
	endtask
	task add_exp(input [7:0] b);
		reg [8:0] s;
		reg [4:0] h;
		reg [7:0] l;
		begin
			s = ea + b;
			h = ea[3:0] + b[3:0];
			l = ea[6:0] + b[6:0];
			ep = {s[8], h[4], 3'b000, s[8] ^ l[7], 2'b00};
			ea = s[7:0];
		end
	endtask
	task t_calls;
		begin
			step;
			check(pc, 16'h0123);
			check(sp, 8'h09);
			check(mem_u.ram[8], 8'h02);
			check(mem_u.ram[9], 8'h00);
			step;
			check(pc, 16'h0345);
			check(mem_u.ram[10], 8'h25);
			check(mem_u.ram[11], 8'h01);
			check(psw, 8'h00);
			check(code_rd, 1'b1);
			check(ram_wr, 1'b0);
			$display("call test done");
		end
	endtask
	task t_adds;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				step;
				add_exp(32'hc3aa_0125 >> (24 - 8 * i));
				check(acc, ea);
				check(psw, ep);
				check(ram_rd, 1'b0);
				check(code_rd, 1'b1);
			end
			$display("add test done");
		end
	endtask
	task final_report;
		begin
			$display("errors %0d compares %0d", n_errors, compares);
			if (n_errors == 0 && compares > 0) $display("All tests passed");
			else $display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		#1;
		{mem_u.rom[0], mem_u.rom[1], mem_u.rom[291], mem_u.rom[292]} = 32'h3123_7145;
		for (i = 0; i < 6; i = i + 1) mem_u.rom[837 + i] = 48'h24c3_2825_0b27 >> (40 - 8 * i);
		mem_u.ram[0] = 8'haa;
		mem_u.ram[1] = 8'h0a;
		repeat (5) @(posedge i_mclk);
		#1 i_srst = 1'b0;
		t_calls;
		t_adds;
		final_report;
	end
endmodule // tb_acx_core
